// ---- logic/tap_defs.svh ----
// Functional notes
// R1 - TMS at TCK rise steers every state change
// R2 - Code 000 captures ring, drives preloaded pins
// R3 - Code 001 selects fixed identification register
// R4 - Code 010 captures, selects chain, outputs high-Z
// R5 - Code 100 captures, selects chain, memory unaffected
// R6 - Code 111 selects one-bit bypass register
// R7 - Controller never loads codes 011, 101, 110; here Update-IR loads any shifted code, and reserved codes shift the chain
// R8 - ID layout: revision, device type, vendor bits
// R9 - ID bit zero always reads one
// R10 - Lengths: IR 3, bypass 1, ID 32, chain 109
// R11 - Shift on TCK rise, TDO changes on fall
// R12 - Cell 108 gates output drivers under EXTEST
// R13 - IR holds IDCODE after reset or five TMS-high
// R14 - Capture-IR loads binary 01 into IR low bits
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH
// ****************************************
// Instruction codes
// ****************************************
`define INS_EXTEST 3'h0
`define INS_IDCODE 3'h1
`define INS_SAMPLE_Z 3'h2
`define INS_SAMPLE 3'h4
`define INS_BYPASS 3'h7
// ****************************************
// Sizes and field positions
// ****************************************
`define IR_LEN 3
`define ID_LEN 32
`define BSR_LEN 109
`define BSR_OE_CELL 108
`define IR_CAPTURE 3'h1
`define ID_REV_LSB 29
`define ID_DEV_LSB 12
`define ID_VEND_LSB 1
`endif

// ---- logic/tap_pkg.sv ----
`include "tap_defs.svh"
package tap_pkg;
   // TAP controller states, Gray-ish along the DR path
   typedef enum logic [3:0] {
      ST_RESET = 4'hF,
      ST_IDLE = 4'hC,
      ST_SEL_DR = 4'h7,
      ST_CAP_DR = 4'h6,
      ST_SHIFT_DR = 4'h2,
      ST_EXIT1_DR = 4'h1,
      ST_PAUSE_DR = 4'h3,
      ST_EXIT2_DR = 4'h0,
      ST_UPD_DR = 4'h5,
      ST_SEL_IR = 4'h4,
      ST_CAP_IR = 4'hE,
      ST_SHIFT_IR = 4'hA,
      ST_EXIT1_IR = 4'h9,
      ST_PAUSE_IR = 4'hB,
      ST_EXIT2_IR = 4'h8,
      ST_UPD_IR = 4'hD
   } tap_state_t;

   // Sampled link pins
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } link_in_t;

   // Whole module state
   typedef struct packed {
      logic [1:0] rst_sync;
      link_in_t s1;
      link_in_t s2;
      logic [`BSR_LEN-2:0] pins_s1;
      logic [`BSR_LEN-2:0] pins_s2;
      logic tck_prev;
      tap_state_t state;
      logic [`IR_LEN-1:0] ir_shift;
      logic [`IR_LEN-1:0] ir;
      logic bypass;
      logic [`ID_LEN-1:0] id_shift;
      logic [`BSR_LEN-1:0] bsr_shift;
      logic [`BSR_LEN-1:0] bsr_upd;
      logic tdo;
      logic tdo_oe;
   } tap_regs_t;
endpackage : tap_pkg

// ---- logic/sram_tap.sv ----
`timescale 1ns/100ps
`include "tap_defs.svh"
module sram_tap
   import tap_pkg::*;
#(
   parameter logic [2:0] REVISION = 3'h0, // Arbitrary value
   parameter logic [16:0] DEVICE_TYPE = 17'h00ABC, // Arbitrary value
   parameter logic [10:0] VENDOR_CODE = 11'h155 // Arbitrary value
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   input wire logic [`BSR_LEN-2:0] pins_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   output logic [`BSR_LEN-2:0] pins_o,
   output logic pins_test_drive_o,
   output logic out_bus_en_o,
   output logic [`IR_LEN-1:0] instr_o
);
   // ****************************************
   // State registers
   // ****************************************
   tap_regs_t s_reg; // Registered state
   tap_regs_t s_next; // Next state
   logic rst_n; // Synchronised reset
   logic rise; // TCK rising edge enable
   logic fall; // TCK falling edge enable
   logic tms; // Synchronised TMS
   logic tdi; // Synchronised TDI
   logic [`ID_LEN-1:0] id_code; // Fixed identification word

   // Capture happens for all chain instructions
   // Reserved codes select the chain for shifting
   // only, so they neither capture nor update
   function automatic logic uses_chain(input logic [2:0] code);
      uses_chain = (code == `INS_EXTEST) || (code == `INS_SAMPLE_Z) || (code == `INS_SAMPLE);
   endfunction : uses_chain

   // ****************************************
   // Synchronised link and edge enables
   // ****************************************
   // Reset copy leaves the second flip-flop
   assign rst_n = s_reg.rst_sync[1];
   // Edges compare the second stage with its own delayed
   // copy, so each enable lasts exactly one fast cycle
   assign rise = s_reg.s2.tck & ~s_reg.tck_prev; // R1
   assign fall = ~s_reg.s2.tck & s_reg.tck_prev; // R11
   // Mode select and data travel beside the clock through
   // the same two stages, so their setup to the edge is kept
   assign tms = s_reg.s2.tms;
   assign tdi = s_reg.s2.tdi;
   // Fixed code with the presence bit at the bottom
   assign id_code = {REVISION, DEVICE_TYPE, VENDOR_CODE, 1'b1}; // R8 R9

   // ****************************************
   // Next state
   // ****************************************
   // One pass works out the whole next state
   always_comb begin
      logic tdo_bit;
      tdo_bit = 1'b0;
      s_next = s_reg;
      s_next.rst_sync = {s_reg.rst_sync[0], 1'b1};
      s_next.s1 = '{tck: tck_i, tms: tms_i, tdi: tdi_i};
      s_next.s2 = s_reg.s1;
      s_next.tck_prev = s_reg.s2.tck;
      // Pin ring crosses into this domain in two stages
      s_next.pins_s1 = pins_i;
      s_next.pins_s2 = s_reg.pins_s1;
      // Controller and shift registers move only on a test clock rise
      if (rise) begin
         // Controller transitions
         case (s_reg.state)
            ST_RESET: s_next.state = tms ? ST_RESET : ST_IDLE; // R1
            ST_IDLE: s_next.state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: s_next.state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: s_next.state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: s_next.state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: s_next.state = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: s_next.state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: s_next.state = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: s_next.state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: s_next.state = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: s_next.state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: s_next.state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: s_next.state = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: s_next.state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: s_next.state = tms ? ST_UPD_IR : ST_SHIFT_IR;
            default: s_next.state = tms ? ST_SEL_DR : ST_IDLE;
         endcase
         // Register actions in the current state
         case (s_reg.state)
            ST_RESET: begin
               s_next.ir = `INS_IDCODE; // R13
               s_next.bsr_upd[`BSR_OE_CELL] = 1'b1; // R12
            end
            ST_CAP_IR: s_next.ir_shift = `IR_CAPTURE; // R14
            ST_SHIFT_IR: s_next.ir_shift = {tdi, s_reg.ir_shift[`IR_LEN-1:1]}; // R11
            ST_UPD_IR: s_next.ir = s_reg.ir_shift;
            ST_CAP_DR: begin
               s_next.bypass = 1'b0; // R6
               s_next.id_shift = id_code; // R3
               if (uses_chain(s_reg.ir)) begin
                  // Pins plus the internal drive-control cell, which
                  // samples its own latch since no pin stands behind it
                  s_next.bsr_shift = {s_reg.bsr_upd[`BSR_OE_CELL], s_reg.pins_s2}; // R2 R4 R5
               end
            end
            ST_SHIFT_DR: begin
               // MSB next to TDI, LSB next to TDO
               s_next.bypass = tdi; // R6
               s_next.id_shift = {tdi, s_reg.id_shift[`ID_LEN-1:1]}; // R3 R10
               s_next.bsr_shift = {tdi, s_reg.bsr_shift[`BSR_LEN-1:1]}; // R10 R11
            end
            ST_UPD_DR: if (uses_chain(s_reg.ir)) s_next.bsr_upd = s_reg.bsr_shift; // R2
            default: s_next.ir = s_reg.ir;
         endcase
         // Entering Test-Logic-Reset restores the instruction and
         // presets the drive cell, whichever state led there
         if (s_next.state == ST_RESET) begin
            s_next.ir = `INS_IDCODE; // R13
            s_next.bsr_upd[`BSR_OE_CELL] = 1'b1; // R12
         end
      end
      if (fall) begin
         // TDO updates on the falling edge only
         case (s_reg.ir)
            `INS_IDCODE: tdo_bit = s_reg.id_shift[0];
            `INS_BYPASS: tdo_bit = s_reg.bypass; // R6
            default: tdo_bit = s_reg.bsr_shift[0]; // R7
         endcase
         // Shift-IR shows the instruction path instead
         s_next.tdo = (s_reg.state == ST_SHIFT_IR) ? s_reg.ir_shift[0] : tdo_bit; // R11
         // Driver enabled only while a path is shifting
         s_next.tdo_oe = (s_reg.state == ST_SHIFT_IR) || (s_reg.state == ST_SHIFT_DR);
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   // Pin reset acts at once; the sync copy keeps the state parked
   // until the release has passed both flip-flops
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // Constants only on the asynchronous path
         s_reg <= '0;
         s_reg.state <= ST_RESET;
         s_reg.ir <= `INS_IDCODE; // R13
         s_reg.bsr_upd <= {1'b1, {(`BSR_LEN-1){1'b0}}}; // R12
      end else if (!rst_n) begin
         // Release still travelling through the synchroniser
         s_reg <= '0;
         s_reg.rst_sync <= s_next.rst_sync;
         s_reg.state <= ST_RESET;
         s_reg.ir <= `INS_IDCODE;
         s_reg.bsr_upd <= {1'b1, {(`BSR_LEN-1){1'b0}}};
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Serial output and its enable straight from flip-flops
   assign tdo_o = s_reg.tdo;
   assign tdo_oe_o = s_reg.tdo_oe;
   // Preloaded values, driven onto the pins only under EXTEST
   assign pins_o = s_reg.bsr_upd[`BSR_LEN-2:0]; // R2
   assign pins_test_drive_o = (s_reg.ir == `INS_EXTEST); // R2
   // Memory drivers: off under SAMPLE Z, cell 108 under EXTEST
   assign out_bus_en_o = (s_reg.ir == `INS_SAMPLE_Z) ? 1'b0 : // R4
      (s_reg.ir == `INS_EXTEST) ? s_reg.bsr_upd[`BSR_OE_CELL] : 1'b1; // R12
   // Current instruction for the memory core
   assign instr_o = s_reg.ir;

   // ****************************************
   // Assertions
   // ****************************************
   // Test-Logic-Reset always shows IDCODE and an enabled drive cell
   a_reset_ir_id: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // R13
      (s_reg.state == ST_RESET) |-> (s_reg.ir == `INS_IDCODE) && s_reg.bsr_upd[`BSR_OE_CELL])
      else $error("IR not IDCODE in reset state");
   // Memory outputs stay off for the whole SAMPLE Z instruction
   a_sample_z_hiz: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // R4
      (s_reg.ir == `INS_SAMPLE_Z) |-> !out_bus_en_o)
      else $error("Outputs driven under SAMPLE Z");
   // Fault-isolation pattern in the instruction shifter
   a_cap_ir_pat: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // R14
      (rise && s_reg.state == ST_CAP_IR) |=> (s_reg.ir_shift[1:0] == 2'b01))
      else $error("Capture-IR pattern wrong");
   // Controller frozen between test clock rises
   a_state_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // R1
      !rise |=> $stable(s_reg.state))
      else $error("State moved without TCK rise");
   // Serial output only moves after a test clock fall
   a_tdo_fall: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // R11
      !fall |=> $stable(tdo_o))
      else $error("TDO moved without TCK fall");
   // Presence bit lands first on the serial output
   a_id_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // R9
      (rise && s_reg.state == ST_CAP_DR) |=> (s_reg.id_shift[0] == 1'b1))
      else $error("ID bit zero not one");
   // Drive-control cell rules the memory outputs under EXTEST
   a_extest_oe: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // R12
      (s_reg.ir == `INS_EXTEST) |-> (out_bus_en_o == s_reg.bsr_upd[`BSR_OE_CELL]))
      else $error("Drive control cell ignored");
   // Bypass cell captures a zero
   a_bypass_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // R6
      (rise && s_reg.state == ST_CAP_DR) |=> !s_reg.bypass)
      else $error("Bypass not cleared on capture");
endmodule : sram_tap

// ---- tb/jtag_host.sv ----
`timescale 1ns/100ps
// ****
// Test controller model: slow TCK, idle low between frames
// ****
module jtag_host (
   input wire logic ref_clk_i,
   input wire logic tdo_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   // One 160 ns TCK period, four fast cycles low and four high;
   // TDO is read late in the high phase and TCK is parked low after
   task automatic step(input logic ms, input logic di, output logic do_bit);
      @(negedge ref_clk_i);
      tms_o = ms;
      tdi_o = di;
      repeat (3) @(negedge ref_clk_i);
      tck_o = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      do_bit = tdo_i;
      @(negedge ref_clk_i);
      tck_o = 1'b0;
   endtask : step
   // Quiet link at time zero
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end
endmodule : jtag_host

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`include "tap_defs.svh"
module testbench;
   import tap_pkg::*;
   localparam logic [2:0] REV = 3'h5; // Arbitrary value
   localparam logic [16:0] DEV = 17'h0A5A5; // Arbitrary value
   localparam logic [10:0] VEN = 11'h2B3; // Arbitrary value
   localparam logic [2:0] CODES [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
   logic ref_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, drive, bus_en, b;
   logic [`BSR_LEN-2:0] pins_in, pins_out;
   logic [2:0] instr;
   logic [`BSR_LEN-1:0] sin, sout;
   int err_total, check_count, cyc;
   sram_tap #(.REVISION(REV), .DEVICE_TYPE(DEV), .VENDOR_CODE(VEN)) u_sram_tap (
      .ref_clk_i(ref_clk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .pins_i(pins_in), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pins_o(pins_out),
      .pins_test_drive_o(drive), .out_bus_en_o(bus_en), .instr_o(instr));
   jtag_host u_jtag_host (.ref_clk_i(ref_clk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms),
      .tdi_o(tdi));
   // ****
   // Helpers
   // ****
   task automatic check(input logic [`BSR_LEN-1:0] got, input logic [`BSR_LEN-1:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic conclude();
      if (err_total == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // Memory driver enable expected for an instruction
   function automatic logic exp_en(input logic [2:0] c, input logic c108);
      return (c == `INS_SAMPLE_Z) ? 1'b0 : ((c == `INS_EXTEST) ? c108 : 1'b1);
   endfunction : exp_en
   // Full scan from Idle back to Idle, LSB first
   task automatic scan(input logic ir, input int n);
      u_jtag_host.step(1'b1, 1'b0, b);
      if (ir) u_jtag_host.step(1'b1, 1'b0, b);
      u_jtag_host.step(1'b0, 1'b0, b);
      u_jtag_host.step(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) u_jtag_host.step(i == n - 1, sin[i], sout[i]);
      check(tdo_oe, 1'b1);
      u_jtag_host.step(1'b1, 1'b0, b);
      u_jtag_host.step(1'b0, 1'b0, b);
      check(tdo_oe, 1'b0);
   endtask : scan
   task automatic irload(input logic [2:0] c);
      sin = '0;
      sin[2:0] = c;
      scan(1'b1, 3);
      check(sout[1:0], 2'b01);
      check(instr, c);
   endtask : irload
   // Fresh random pin ring and shift pattern
   task automatic rnd();
      foreach (sin[i]) sin[i] = 1'($urandom);
      foreach (pins_in[i]) pins_in[i] = 1'($urandom);
   endtask : rnd
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   // ****
   // Main sequence
   // ****
   initial begin
      err_total = 0;
      check_count = 0;
      cyc = 0;
      rst_n = 1'b0;
      pins_in = '0;
      void'($urandom(32'h4c380594));
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(instr, `INS_IDCODE);
      check({tdo_oe, bus_en, drive}, 3'b010);
      u_jtag_host.step(1'b0, 1'b0, b);
      sin = '0;
      scan(1'b0, 32);
      check(sout[31:0], {REV, DEV, VEN, 1'b1});
      foreach (CODES[k]) begin
         irload(CODES[k]);
         check({bus_en, drive}, {exp_en(CODES[k], 1'b1), CODES[k] == `INS_EXTEST});
      end
      rnd();
      scan(1'b0, 20);
      check(sout[19:0], {sin[18:0], 1'b0});
      irload(`INS_SAMPLE);
      rnd();
      sin[`BSR_OE_CELL] = 1'b0;
      scan(1'b0, `BSR_LEN);
      check(sout, {1'b1, pins_in});
      check(pins_out, sin[`BSR_LEN-2:0]);
      irload(`INS_EXTEST);
      check({bus_en, drive}, 2'b01);
      foreach (pins_in[i]) pins_in[i] = 1'($urandom);
      scan(1'b0, `BSR_LEN);
      check(sout, {1'b0, pins_in});
      for (int i = 0; i < 6; i++) u_jtag_host.step(i < 5, 1'b0, b);
      check(instr, `INS_IDCODE);
      irload(`INS_EXTEST);
      check(bus_en, 1'b1);
      conclude();
   end
endmodule : testbench
